// ==== pkg/qas_pkg.sv ====
// Shared constants and types for the four-converter summing pipeline
package qas_pkg;
	localparam int unsigned QAS_N_CONV = 4;
	localparam int unsigned QAS_IN_W = 16;
	localparam int unsigned QAS_OUT_W = 16;
	localparam int unsigned QAS_LATENCY = 10;
	localparam int unsigned QAS_FIFO_DEPTH = 16;
	localparam logic [15:0] QAS_CODE_MIN = 16'h0000;
	localparam logic [15:0] QAS_CODE_MID = 16'h8000;
	localparam logic [15:0] QAS_CODE_MAX = 16'hFFFF;
	localparam logic [15:0] QAS_WORD_RST = 16'h0000;
	localparam logic QAS_VALID_RST = 1'b0;
	typedef logic [QAS_OUT_W-1:0] qas_word_t;
endpackage : qas_pkg

// ==== rtl/qas_fifo.sv ====
// Show-ahead flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module qas_fifo #(
	parameter int unsigned W = 16,
	parameter int unsigned DEPTH = 16
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import qas_pkg::*;
	localparam int unsigned AW = $clog2(DEPTH);

	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic [W-1:0] mem_q [DEPTH];
	wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire empty = (wr_q == rd_q);
	wire push = ce & in_valid & ~full;
	wire pop = ce & ~empty & out_ready;

	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = mem_q[rd_q[AW-1:0]];

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + (AW+1)'(1);
			end
			if (pop) begin
				rd_q <= rd_q + (AW+1)'(1);
			end
		end
	end

	for (genvar e = 0; e < DEPTH; e++) begin : g_entry
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mem_q[e] <= W'(QAS_WORD_RST);
			end else if (push && (wr_q[AW-1:0] == AW'(e))) begin
				mem_q[e] <= in_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_FIFO_NO_PUSH_WHEN_FULL: assert property (@(posedge clk) disable iff (!rst_n)
		(full && !pop) |=> (wr_q == $past(wr_q))) else $error("FIFO pointer moved while full");
endmodule : qas_fifo

// ==== rtl/qas_sum_pipeline.sv ====
// Four-converter summing pipeline with output FIFO
`timescale 1ns/10ps
module qas_sum_pipeline #(
	parameter int unsigned IN_W = qas_pkg::QAS_IN_W,
	parameter int unsigned LAT = qas_pkg::QAS_LATENCY,
	parameter int unsigned FIFO_DEPTH = qas_pkg::QAS_FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	// Converter results
	input wire logic IN_VALID,
	input wire logic [IN_W-1:0] CONV0_DATA,
	input wire logic [IN_W-1:0] CONV1_DATA,
	input wire logic [IN_W-1:0] CONV2_DATA,
	input wire logic [IN_W-1:0] CONV3_DATA,
	// Input flow status
	output logic SAMPLE_READY,
	output logic OVERRUN,
	// Summed output
	output qas_pkg::qas_word_t DOUT,
	output logic OUTPUT_VALID_STROBE,
	input wire logic OUT_READY
);
	import qas_pkg::*;

	localparam int unsigned SUM_W = IN_W + 2;
	localparam int unsigned NDLY = LAT - 2;
	localparam logic [IN_W-1:0] IN_MID = {1'b1, {(IN_W-1){1'b0}}};
	localparam logic [IN_W-1:0] IN_MAX = {IN_W{1'b1}};
	localparam logic [IN_W-1:0] IN_MIN = {IN_W{1'b0}};

	////////////////////////////////////////////////////////////////////////
	// Flow control
	logic [LAT-1:0] vld_q;
	logic [LAT-1:0] vld_d;
	logic fifo_in_ready;
	logic overrun_q;
	wire adv = CE & (~vld_q[LAT-1] | fifo_in_ready);
	wire take = adv & IN_VALID;
	wire drop = CE & IN_VALID & ~adv;

	assign SAMPLE_READY = adv;
	assign OVERRUN = overrun_q;
	assign vld_d = {vld_q[LAT-2:0], IN_VALID};

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			vld_q <= {LAT{QAS_VALID_RST}};
		end else if (adv) begin
			vld_q <= vld_d;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			overrun_q <= QAS_VALID_RST;
		end else if (CE) begin
			overrun_q <= drop;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input capture, all four on one edge
	logic [IN_W-1:0] conv_in [QAS_N_CONV];
	logic [IN_W-1:0] cnv_q [QAS_N_CONV];

	assign conv_in[0] = CONV0_DATA;
	assign conv_in[1] = CONV1_DATA;
	assign conv_in[2] = CONV2_DATA;
	assign conv_in[3] = CONV3_DATA;

	for (genvar k = 0; k < QAS_N_CONV; k++) begin : g_conv
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				cnv_q[k] <= '0;
			end else if (adv) begin
				cnv_q[k] <= conv_in[k];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Ripple-carry adders: two pair sums, then the final sum
	wire [SUM_W-1:0] op0 = {2'b00, cnv_q[0]};
	wire [SUM_W-1:0] op1 = {2'b00, cnv_q[1]};
	wire [SUM_W-1:0] op2 = {2'b00, cnv_q[2]};
	wire [SUM_W-1:0] op3 = {2'b00, cnv_q[3]};
	logic [SUM_W-1:0] p01_q;
	logic [SUM_W-1:0] p23_q;
	logic [SUM_W-1:0] s01;
	logic [SUM_W-1:0] s23;
	logic [SUM_W-1:0] sfin;
	logic [SUM_W:0] c01;
	logic [SUM_W:0] c23;
	logic [SUM_W:0] cfin;

	assign c01[0] = 1'b0;
	assign c23[0] = 1'b0;
	assign cfin[0] = 1'b0;

	for (genvar b = 0; b < SUM_W; b++) begin : g_rca
		assign s01[b] = op0[b] ^ op1[b] ^ c01[b];
		assign c01[b+1] = (op0[b] & op1[b]) | (c01[b] & (op0[b] ^ op1[b]));
		assign s23[b] = op2[b] ^ op3[b] ^ c23[b];
		assign c23[b+1] = (op2[b] & op3[b]) | (c23[b] & (op2[b] ^ op3[b]));
		assign sfin[b] = p01_q[b] ^ p23_q[b] ^ cfin[b];
		assign cfin[b+1] = (p01_q[b] & p23_q[b]) | (cfin[b] & (p01_q[b] ^ p23_q[b]));
	end

	// Divide by four keeps offset binary: midscale stays midscale
	wire qas_word_t sum_word = sfin[SUM_W-1 -: QAS_OUT_W];

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			p01_q <= '0;
			p23_q <= '0;
		end else if (adv) begin
			p01_q <= s01;
			p23_q <= s23;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Delay line up to the fixed latency
	qas_word_t pipe_q [NDLY];

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pipe_q[0] <= QAS_WORD_RST;
		end else if (adv) begin
			pipe_q[0] <= sum_word;
		end
	end

	for (genvar j = 1; j < NDLY; j++) begin : g_dly
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				pipe_q[j] <= QAS_WORD_RST;
			end else if (adv) begin
				pipe_q[j] <= pipe_q[j-1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output buffer
	qas_fifo #(
		.W(QAS_OUT_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.in_valid(vld_q[LAT-1]),
		.in_ready(fifo_in_ready),
		.in_data(pipe_q[NDLY-1]),
		.out_valid(OUTPUT_VALID_STROBE),
		.out_ready(OUT_READY),
		.out_data(DOUT)
	);

	////////////////////////////////////////////////////////////////////////
	// Checking helpers
	logic [4:0] adv_run_q;
	wire wr_fire = CE & vld_q[LAT-1] & fifo_in_ready;
	wire [SUM_W-1:0] raw_sum = {2'b00, CONV0_DATA} + {2'b00, CONV1_DATA} + {2'b00, CONV2_DATA} + {2'b00, CONV3_DATA};
	wire qas_word_t raw_word = raw_sum[SUM_W-1 -: QAS_OUT_W];
	wire all_mid = (CONV0_DATA == IN_MID) && (CONV1_DATA == IN_MID) && (CONV2_DATA == IN_MID) && (CONV3_DATA == IN_MID);
	wire all_max = (CONV0_DATA == IN_MAX) && (CONV1_DATA == IN_MAX) && (CONV2_DATA == IN_MAX) && (CONV3_DATA == IN_MAX);
	wire all_min = (CONV0_DATA == IN_MIN) && (CONV1_DATA == IN_MIN) && (CONV2_DATA == IN_MIN) && (CONV3_DATA == IN_MIN);
	wire full_run = (adv_run_q >= 5'(LAT));

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			adv_run_q <= '0;
		end else if (!adv) begin
			adv_run_q <= '0;
		end else if (adv_run_q != 5'h1F) begin
			adv_run_q <= adv_run_q + 5'h01;
		end
	end

	sequence s_take;
		take;
	endsequence

	sequence s_flow;
		adv [*8] ##1 adv;
	endsequence

	////////////////////////////////////////////////////////////////////////
	AST_SUM_LATENCY: assert property (@(posedge CLK) disable iff (!RST_N)
		(wr_fire && full_run) |-> (pipe_q[NDLY-1] == $past(raw_word, LAT)))
		else $error("Summed word does not match inputs ten cycles earlier");

	AST_PIPE_FILL: assert property (@(posedge CLK) disable iff (!RST_N)
		(s_take ##1 s_flow) |=> vld_q[LAT-1])
		else $error("Sample did not reach last stage after ten advances");

	AST_MIDSCALE: assert property (@(posedge CLK) disable iff (!RST_N)
		(wr_fire && full_run && $past(all_mid, LAT)) |-> (pipe_q[NDLY-1] == QAS_CODE_MID))
		else $error("Midscale inputs did not give code 32768");

	AST_FULLSCALE: assert property (@(posedge CLK) disable iff (!RST_N)
		(wr_fire && full_run && $past(all_max, LAT)) |-> (pipe_q[NDLY-1] == QAS_CODE_MAX))
		else $error("Full-scale inputs did not give code 65535");

	AST_ZEROSCALE: assert property (@(posedge CLK) disable iff (!RST_N)
		(wr_fire && full_run && $past(all_min, LAT)) |-> (pipe_q[NDLY-1] == QAS_CODE_MIN))
		else $error("Bottom-scale inputs did not give code 0");

	AST_STALL_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
		(CE && vld_q[LAT-1] && !fifo_in_ready && !OUT_READY) |=> ($stable(pipe_q[NDLY-1]) && vld_q[LAT-1] && !SAMPLE_READY))
		else $error("Last stage moved while output buffer was full");

	AST_OUT_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
		(OUTPUT_VALID_STROBE && !OUT_READY) |=> (OUTPUT_VALID_STROBE && $stable(DOUT)))
		else $error("Output word changed before it was taken");

	AST_CE_FREEZE: assert property (@(posedge CLK) disable iff (!RST_N)
		(!CE) |=> ($stable(vld_q) && $stable(DOUT) && $stable(OUTPUT_VALID_STROBE)))
		else $error("State moved while clock enable was low");

	AST_OVERRUN: assert property (@(posedge CLK) disable iff (!RST_N)
		(CE && IN_VALID && !SAMPLE_READY) |=> OVERRUN ##1 (!OVERRUN || $past(drop) || !$past(CE)))
		else $error("Dropped sample not flagged for one cycle");

	AST_SAME_EDGE: assert property (@(posedge CLK) disable iff (!RST_N)
		take |=> ((cnv_q[0] == $past(CONV0_DATA)) && (cnv_q[3] == $past(CONV3_DATA))))
		else $error("Converter results not captured on the same edge");
endmodule : qas_sum_pipeline

// ==== verification/qas_conv_model.sv ====
// Behavioural model of the four parallel converters
`timescale 1ns/10ps
module qas_conv_model (
	// Clock and request
	input wire logic clk,
	input wire logic req,
	input wire logic [15:0] val,
	input wire logic [15:0] dev,
	// Converter results
	output logic valid,
	output logic [15:0] c0,
	output logic [15:0] c1,
	output logic [15:0] c2,
	output logic [15:0] c3
);
	initial begin
		valid = 1'b0;
		{c0, c1, c2, c3} = 64'h0;
	end
	////////////////////////////////////////////////////////////////
	// All four sample together on the shared rising edge
	always @(posedge clk) begin
		valid <= req;
		if (req) begin
			c0 <= val + dev;
			c1 <= val - dev;
			c2 <= val;
			c3 <= val ^ dev;
		end else begin
			{c0, c1, c2, c3} <= ~{c0, c1, c2, c3};
		end
	end
endmodule : qas_conv_model

// ==== verification/qas_sum_pipeline_test.sv ====
// Self-checking bench for the summing pipeline
`timescale 1ns/10ps
module qas_sum_pipeline_test;
	import qas_pkg::*;
	logic clk, rst_n, ce, req, out_ready, in_valid, sample_ready, overrun, out_valid;
	logic [15:0] val, dev, c0, c1, c2, c3;
	qas_word_t dout;
	qas_word_t exp_q[$];
	qas_word_t codes[3] = '{QAS_CODE_MIN, QAS_CODE_MID, QAS_CODE_MAX};
	int n_mismatch = 0;
	int tests_run = 0;
	int n_lost = 0;
	int n_ovr = 0;
	qas_conv_model conv (.clk(clk), .req(req), .val(val), .dev(dev), .valid(in_valid),
		.c0(c0), .c1(c1), .c2(c2), .c3(c3));
	qas_sum_pipeline dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .IN_VALID(in_valid),
		.CONV0_DATA(c0), .CONV1_DATA(c1), .CONV2_DATA(c2), .CONV3_DATA(c3),
		.SAMPLE_READY(sample_ready), .OVERRUN(overrun), .DOUT(dout),
		.OUTPUT_VALID_STROBE(out_valid), .OUT_READY(out_ready));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic qas_word_t f_avg(input logic [15:0] a, b, c, d);
		logic [17:0] s;
		s = {2'b00, a} + {2'b00, b} + {2'b00, c} + {2'b00, d};
		return s[17:2];
	endfunction : f_avg
	// Monitor: takes, losses and pops
	always @(posedge clk) begin
		if (rst_n && ce && in_valid && sample_ready) exp_q.push_back(f_avg(c0, c1, c2, c3));
		if (rst_n && ce && in_valid && !sample_ready) n_lost++;
		if (rst_n && overrun) n_ovr++;
		if (rst_n && ce && out_valid && out_ready) begin
			if (exp_q.size() == 0) chk("pop empty", 16'h0001, 16'h0000);
			else chk("dout", dout, exp_q.pop_front());
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("rst dout", dout, QAS_WORD_RST);
		chk("rst vld", {15'h0, out_valid}, {15'h0, QAS_VALID_RST});
		chk("rst rdy", {15'h0, sample_ready}, {15'h0, ce});
		exp_q.delete();
		@(posedge clk) rst_n <= 1'b1;
		$display("test reset done");
	endtask : t_reset
	task automatic t_latency;
		int n;
		@(posedge clk) begin req <= 1'b1; val <= 16'h1234; dev <= 16'h0100; end
		@(posedge clk) req <= 1'b0;
		@(posedge clk);
		n = 0;
		do begin @(posedge clk); n++; #1; end while (out_valid !== 1'b1 && n < 20);
		chk("latency", 16'(n), 16'(QAS_LATENCY));
		$display("test latency done");
	endtask : t_latency
	task automatic t_codes;
		@(posedge clk) begin out_ready <= 1'b0; dev <= 16'h0000; end
		for (int i = 0; i < 3; i++) @(posedge clk) begin req <= 1'b1; val <= codes[i]; end
		@(posedge clk) req <= 1'b0;
		repeat (14) @(posedge clk);
		out_ready <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			#1 if (i < 2) chk("code", dout, codes[i + 1]);
		end
		$display("test codes done");
	endtask : t_codes
	task automatic t_fill;
		int k;
		qas_word_t d0;
		@(posedge clk) begin out_ready <= 1'b0; dev <= 16'h0011; end
		n_lost = 0;
		n_ovr = 0;
		for (int i = 0; i < 40; i++) @(posedge clk) begin req <= 1'b1; val <= 16'(i * 16'h0400); end
		@(posedge clk) req <= 1'b0;
		repeat (3) @(posedge clk);
		chk("lost", 16'(n_lost > 0), 16'h0001);
		chk("lost n", 16'(n_lost), 16'(40 - QAS_LATENCY - QAS_FIFO_DEPTH));
		chk("overrun", 16'(n_ovr), 16'(n_lost));
		k = exp_q.size();
		d0 = dout;
		@(posedge clk) begin ce <= 1'b0; out_ready <= 1'b1; end
		repeat (5) @(posedge clk);
		#1 chk("ce hold", dout, d0);
		chk("ce count", 16'(exp_q.size()), 16'(k));
		@(posedge clk) ce <= 1'b1;
		k = 0;
		do begin @(posedge clk); k++; #1; end while (out_valid !== 1'b0 && k < 80);
		chk("left", 16'(exp_q.size()), 16'h0000);
		$display("test fill done");
	endtask : t_fill
	task automatic t_flush;
		@(posedge clk) req <= 1'b1;
		@(posedge clk) req <= 1'b0;
		repeat (5) @(posedge clk);
		t_reset();
		repeat (15) @(posedge clk);
		#1 chk("flush", {15'h0, out_valid}, 16'h0000);
		$display("test flush done");
	endtask : t_flush
	task automatic summarize;
		$display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////
	initial begin
		#20000;
		n_mismatch++;
		summarize();
	end
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		req = 1'b0;
		val = 16'h0000;
		dev = 16'h0000;
		out_ready = 1'b1;
		t_reset();
		t_latency();
		t_codes();
		t_fill();
		t_flush();
		summarize();
	end
endmodule : qas_sum_pipeline_test
